// ### inc/mei_pkg.sv
// Purpose: Shared constants and types of the monitor control and indicator block.
// Assumes: 20 MHz aclk, AXI4-Lite register access with 32-bit data.
// Notes: Threshold defaults are plain starting values, restored on factory reset.
package mei_pkg;
    // Clock and timing
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned DEBOUNCE_MS = 10;
    localparam int unsigned DEBOUNCE_CYC = (CLK_HZ / 1000) * DEBOUNCE_MS;
    localparam int unsigned FACTORY_HOLD_S = 10;
    localparam int unsigned FACTORY_HOLD_CYC = CLK_HZ * FACTORY_HOLD_S;
    localparam int unsigned CNT_W = 32;

    // Event classes, one live and one latched lamp each
    localparam int NCLS = 8;
    localparam int EV_ACTIVE_ERR = 0;
    localparam int EV_PASSIVE_ERR = 1;
    localparam int EV_OVERLOAD = 2;
    localparam int EV_ACK = 3;
    localparam int EV_QUAL = 4;
    localparam int EV_VOLT = 5;
    localparam int EV_EDGE_UP = 6;
    localparam int EV_EDGE_DN = 7;

    // Measurement widths and threshold defaults
    localparam int QUAL_W = 7;
    localparam int VOLT_W = 12;
    localparam int EDGE_W = 7;
    localparam logic [QUAL_W-1:0] QUAL_THR_DEF = 7'h32;
    localparam logic [VOLT_W-1:0] VOLT_MIN_DEF = 12'h4b0;
    localparam logic [EDGE_W-1:0] EDGE_LIM_DEF = 7'h10;

    // Register map, byte addresses
    localparam int ADDR_W = 6;
    localparam logic [ADDR_W-1:0] OFF_CTRL = 6'h00;
    localparam logic [ADDR_W-1:0] OFF_STATE = 6'h04;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 6'h08;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 6'h0c;
    localparam logic [ADDR_W-1:0] OFF_ERR_ROUTE = 6'h10;
    localparam logic [ADDR_W-1:0] OFF_QUAL_THR = 6'h14;
    localparam logic [ADDR_W-1:0] OFF_VOLT_MIN = 6'h18;
    localparam logic [ADDR_W-1:0] OFF_EDGE_UP_LIM = 6'h1c;
    localparam logic [ADDR_W-1:0] OFF_EDGE_DN_LIM = 6'h20;

    // Field positions
    localparam int CTRL_TOGGLE_BIT = 0;
    localparam int STATE_RUN_BIT = 0;
    localparam int STATE_LIVE_LSB = 8;
    localparam int STATE_LATCH_LSB = 16;
    localparam int ST_START = 8;
    localparam int ST_STOP = 9;
    localparam int ST_FACTORY = 10;
    localparam int STATUS_W = 11;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic {mei_idle, mei_running} mei_mode_t;
endpackage

// ### inc/mei_btn_if.sv
// Purpose: Debounced button state handed from the debouncer to the control logic.
// Assumes: Both ends on aclk.
// Notes: press is a one-cycle pulse on each confirmed release-to-press change.
`timescale 1ns/1ps
`default_nettype none
interface mei_btn_if;
    logic stable;
    logic press;
    modport src(output stable, output press);
    modport dst(input stable, input press);
endinterface
`default_nettype wire

// ### logic/mei_debounce.sv
// Purpose: Synchronise and debounce one front or rear panel push button.
// Assumes: Raw pin is asynchronous and active high while pressed.
// Notes: Level must hold DB_CYCLES cycles before the stable state follows.
`timescale 1ns/1ps
`default_nettype none
module mei_debounce import mei_pkg::*; #(
    parameter int unsigned DB_CYCLES = DEBOUNCE_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic pin_raw,
    mei_btn_if.src btn
);
    logic sync1_r, sync2_r, stable_r, press_r;
    logic [CNT_W-1:0] cnt_r;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Two-stage synchroniser; only sync2_r feeds logic
    always_ff @(posedge aclk) begin
        sync1_r <= aresetn ? pin_raw : 1'b0;
        sync2_r <= aresetn ? sync1_r : 1'b0;
    end

    wire differs = sync2_r != stable_r;
    wire settled = differs && (cnt_r == CNT_W'(DB_CYCLES - 1));

    // (R14) Bounce filter
    // A change is accepted only after it held long enough, so bounce restarts the count
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_r <= '0;
            stable_r <= 1'b0;
            press_r <= 1'b0;
        end else begin
            cnt_r <= (differs && !settled) ? cnt_r + 1'b1 : '0;
            stable_r <= settled ? sync2_r : stable_r;
            press_r <= settled && sync2_r;
        end
    end

    assign btn.stable = stable_r;
    assign btn.press = press_r;

    a_single_press: assert property (press_r |=> !press_r) // R14
        else $error("press pulse longer than one cycle");
endmodule
`default_nettype wire

// ### logic/mei_top.sv
// Purpose: Run control, lamps and event indicators of a CAN bus monitor.
// Assumes: Event, traffic and measurement inputs come from logic on aclk.
// Notes: Buttons are raw pins and are synchronised and debounced here.
//
// Behaviour
// (R1) Run button toggles monitoring on and off
// (R2) Run lamp green exactly while monitoring
// (R3) Bus lamp shows present bus traffic
// (R4) Each event class has live, latched lamp
// (R5) Four logical classes: errors, overload, acknowledge
// (R6) Quality event when quality below threshold
// (R7) Voltage event when margin below minimum
// (R8) Edge events when slowest edge exceeds limit
// (R9) Starting monitoring clears all error lamps
// (R10) Live lamp needs condition and monitoring
// (R11) Latched lamp holds until next start
// (R12) Routed events mirror on isolated output
// (R13) Ten second reset hold restores defaults
// (R14) Debounce run button, one toggle per press
//
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module mei_top import mei_pkg::*; #(
    parameter int unsigned DEBOUNCE_CYCLES = DEBOUNCE_CYC,
    parameter int unsigned HOLD_CYCLES = FACTORY_HOLD_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic run_btn_pin,
    input wire logic reset_btn_pin,
    input wire logic bus_traffic,
    input wire logic active_error_frame_event,
    input wire logic passive_error_frame_event,
    input wire logic overload_frame_event,
    input wire logic ack_error_event,
    input wire logic [QUAL_W-1:0] meas_quality,
    input wire logic [VOLT_W-1:0] meas_volt_margin,
    input wire logic [EDGE_W-1:0] meas_edge_up,
    input wire logic [EDGE_W-1:0] meas_edge_down,
    output logic run_lamp_green,
    output logic bus_lamp,
    output logic [NCLS-1:0] live_led,
    output logic [NCLS-1:0] latch_led,
    output logic iso_err_out,
    output logic factory_reset,
    output logic irq
);
    mei_btn_if run_btn();
    mei_btn_if rst_btn();

    // Panel buttons share one debouncer design
    mei_debounce #(.DB_CYCLES(DEBOUNCE_CYCLES)) u_run_db (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_raw(run_btn_pin),
        .btn(run_btn.src)
    );
    mei_debounce #(.DB_CYCLES(DEBOUNCE_CYCLES)) u_rst_db (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_raw(reset_btn_pin),
        .btn(rst_btn.src)
    );

    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] dat,
                                           input logic [31:0] msk);
        wmerge = (old & ~msk) | (dat & msk);
    endfunction

    // Bus slave state
    logic aw_held_r, w_held_r, bvalid_r, rvalid_r;
    logic [ADDR_W-1:0] awaddr_r;
    logic [31:0] wdata_r, rdata_r;
    logic [3:0] wstrb_r;
    logic [1:0] bresp_r, rresp_r;

    // Block state
    mei_mode_t mode_r, mode_nxt;
    logic [NCLS-1:0] cond_r, live_r, latch_r;
    logic [NCLS-1:0] route_r;
    logic [STATUS_W-1:0] status_r, mask_r;
    logic [QUAL_W-1:0] qual_thr_r;
    logic [VOLT_W-1:0] volt_min_r;
    logic [EDGE_W-1:0] up_lim_r, dn_lim_r;
    logic [CNT_W-1:0] hold_cnt_r;
    logic bus_lamp_r, iso_r, irq_r, factory_r;

    // Write channel decode; address and data may arrive in either order
    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready = !w_held_r && !bvalid_r;
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire wr_go = aw_held_r && w_held_r && !bvalid_r;
    wire [31:0] wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
    wire wr_ctrl = wr_go && (awaddr_r == OFF_CTRL);
    wire wr_status = wr_go && (awaddr_r == OFF_IRQ_STATUS);
    wire wr_mask = wr_go && (awaddr_r == OFF_IRQ_MASK);
    wire wr_route = wr_go && (awaddr_r == OFF_ERR_ROUTE);
    wire wr_qual = wr_go && (awaddr_r == OFF_QUAL_THR);
    wire wr_volt = wr_go && (awaddr_r == OFF_VOLT_MIN);
    wire wr_up = wr_go && (awaddr_r == OFF_EDGE_UP_LIM);
    wire wr_dn = wr_go && (awaddr_r == OFF_EDGE_DN_LIM);
    wire wr_hit = wr_ctrl || wr_status || wr_mask || wr_route || wr_qual || wr_volt
                  || wr_up || wr_dn || (wr_go && (awaddr_r == OFF_STATE));
    wire [31:0] m_ctrl = wdata_r & wmask;
    wire [31:0] m_mask = wmerge({{(32 - STATUS_W){1'b0}}, mask_r}, wdata_r, wmask);
    wire [31:0] m_route = wmerge({{(32 - NCLS){1'b0}}, route_r}, wdata_r, wmask);
    wire [31:0] m_qual = wmerge({{(32 - QUAL_W){1'b0}}, qual_thr_r}, wdata_r, wmask);
    wire [31:0] m_volt = wmerge({{(32 - VOLT_W){1'b0}}, volt_min_r}, wdata_r, wmask);
    wire [31:0] m_up = wmerge({{(32 - EDGE_W){1'b0}}, up_lim_r}, wdata_r, wmask);
    wire [31:0] m_dn = wmerge({{(32 - EDGE_W){1'b0}}, dn_lim_r}, wdata_r, wmask);

    // Write channel; one write under way, response only after both halves
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
        end else begin
            aw_held_r <= !wr_go && (aw_held_r || aw_take);
            w_held_r <= !wr_go && (w_held_r || w_take);
            awaddr_r <= aw_take ? s_axi_awaddr : awaddr_r;
            wdata_r <= w_take ? s_axi_wdata : wdata_r;
            wstrb_r <= w_take ? s_axi_wstrb : wstrb_r;
            bvalid_r <= wr_go || (bvalid_r && !s_axi_bready);
            bresp_r <= wr_go ? (wr_hit ? RESP_OKAY : RESP_SLVERR) : bresp_r;
        end
    end

    // Read decode; unmapped addresses read zero with an error response
    assign s_axi_arready = !rvalid_r;
    wire ar_take = s_axi_arvalid && s_axi_arready;
    wire [31:0] state_word = {{(32 - STATE_LATCH_LSB - NCLS){1'b0}}, latch_r,
                              live_r, 7'h00, mode_r == mei_running};
    wire rd_hit = s_axi_araddr == OFF_CTRL || s_axi_araddr == OFF_STATE
                  || s_axi_araddr == OFF_IRQ_STATUS || s_axi_araddr == OFF_IRQ_MASK
                  || s_axi_araddr == OFF_ERR_ROUTE || s_axi_araddr == OFF_QUAL_THR
                  || s_axi_araddr == OFF_VOLT_MIN || s_axi_araddr == OFF_EDGE_UP_LIM
                  || s_axi_araddr == OFF_EDGE_DN_LIM;
    wire [31:0] rd_val =
        (s_axi_araddr == OFF_STATE) ? state_word :
        (s_axi_araddr == OFF_IRQ_STATUS) ? {{(32 - STATUS_W){1'b0}}, status_r} :
        (s_axi_araddr == OFF_IRQ_MASK) ? {{(32 - STATUS_W){1'b0}}, mask_r} :
        (s_axi_araddr == OFF_ERR_ROUTE) ? {{(32 - NCLS){1'b0}}, route_r} :
        (s_axi_araddr == OFF_QUAL_THR) ? {{(32 - QUAL_W){1'b0}}, qual_thr_r} :
        (s_axi_araddr == OFF_VOLT_MIN) ? {{(32 - VOLT_W){1'b0}}, volt_min_r} :
        (s_axi_araddr == OFF_EDGE_UP_LIM) ? {{(32 - EDGE_W){1'b0}}, up_lim_r} :
        (s_axi_araddr == OFF_EDGE_DN_LIM) ? {{(32 - EDGE_W){1'b0}}, dn_lim_r} : 32'h0000_0000;

    // Read channel; data held until rready
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= RESP_OKAY;
        end else begin
            rvalid_r <= ar_take || (rvalid_r && !s_axi_rready);
            rdata_r <= ar_take ? rd_val : rdata_r;
            rresp_r <= ar_take ? (rd_hit ? RESP_OKAY : RESP_SLVERR) : rresp_r;
        end
    end

    // (R1) Run toggle request
    // Software toggle shares the button path so both obey the same sequencing
    wire toggle_req = run_btn.press || (wr_ctrl && m_ctrl[CTRL_TOGGLE_BIT]);

    // (R1) Run state
    // A factory restore also stops monitoring ahead of the restart
    always_comb begin
        unique case (mode_r)
            mei_idle: mode_nxt = (toggle_req && !factory_r) ? mei_running : mei_idle;
            mei_running: mode_nxt = (toggle_req || factory_r) ? mei_idle : mei_running;
        endcase
    end

    wire run = mode_r == mei_running;
    wire start_evt = !run && (mode_nxt == mei_running);
    wire stop_evt = run && (mode_nxt == mei_idle);

    // (R5) (R6) (R7) (R8) Event conditions
    // Compared against live thresholds; registered to cut the comparator path
    wire [NCLS-1:0] cond_nxt = {
        meas_edge_down > dn_lim_r,
        meas_edge_up > up_lim_r,
        meas_volt_margin < volt_min_r,
        meas_quality < qual_thr_r,
        ack_error_event,
        overload_frame_event,
        passive_error_frame_event,
        active_error_frame_event
    };

    // (R9) (R11) Latch update, cleared only by a new start
    wire [NCLS-1:0] latch_nxt = start_evt ? '0 : (latch_r | (cond_r & {NCLS{run}}));
    wire [NCLS-1:0] first_hit = cond_r & {NCLS{run}} & ~latch_r;
    wire [STATUS_W-1:0] ev_set = {factory_r, stop_evt, start_evt, first_hit};
    wire [STATUS_W-1:0] w1c = wr_status ? wdata_r[STATUS_W-1:0] & wmask[STATUS_W-1:0] : '0;

    // Run state and event lamps
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_r <= mei_idle;
            cond_r <= '0;
            live_r <= '0;
            latch_r <= '0;
        end else begin
            mode_r <= mode_nxt;
            cond_r <= cond_nxt;
            // (R4) (R10) Live lamps gated by monitoring
            live_r <= cond_r & {NCLS{run}};
            latch_r <= latch_nxt;
        end
    end

    // Sticky status: a new event beats a simultaneous write-one clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_r <= '0;
            mask_r <= '0;
            irq_r <= 1'b0;
        end else begin
            status_r <= (status_r & ~w1c) | ev_set;
            mask_r <= wr_mask ? m_mask[STATUS_W-1:0] : mask_r;
            irq_r <= |(status_r & mask_r);
        end
    end

    // (R13) Reset-button hold timer
    // Counter saturates so one long hold gives exactly one restore pulse
    wire hold_done = hold_cnt_r == CNT_W'(HOLD_CYCLES - 1);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hold_cnt_r <= '0;
            factory_r <= 1'b0;
        end else begin
            hold_cnt_r <= !rst_btn.stable ? '0 :
                          (hold_cnt_r == CNT_W'(HOLD_CYCLES)) ? hold_cnt_r : hold_cnt_r + 1'b1;
            factory_r <= rst_btn.stable && hold_done;
        end
    end

    // (R13) Configuration with factory restore
    always_ff @(posedge aclk) begin
        if (!aresetn || factory_r) begin
            route_r <= '0;
            qual_thr_r <= QUAL_THR_DEF;
            volt_min_r <= VOLT_MIN_DEF;
            up_lim_r <= EDGE_LIM_DEF;
            dn_lim_r <= EDGE_LIM_DEF;
        end else begin
            route_r <= wr_route ? m_route[NCLS-1:0] : route_r;
            qual_thr_r <= wr_qual ? m_qual[QUAL_W-1:0] : qual_thr_r;
            volt_min_r <= wr_volt ? m_volt[VOLT_W-1:0] : volt_min_r;
            up_lim_r <= wr_up ? m_up[EDGE_W-1:0] : up_lim_r;
            dn_lim_r <= wr_dn ? m_dn[EDGE_W-1:0] : dn_lim_r;
        end
    end

    // (R3) (R12) Bus lamp and isolated error output
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bus_lamp_r <= 1'b0;
            iso_r <= 1'b0;
        end else begin
            bus_lamp_r <= bus_traffic;
            iso_r <= |(live_r & route_r);
        end
    end

    // Outputs
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    // (R2) Lamp straight from run state
    assign run_lamp_green = run;
    assign bus_lamp = bus_lamp_r;
    assign live_led = live_r;
    assign latch_led = latch_r;
    assign iso_err_out = iso_r;
    assign factory_reset = factory_r;
    assign irq = irq_r;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_press_toggles: assert property (run_btn.press && !factory_r |=> run != $past(run)) // R1
        else $error("press did not toggle monitoring");
    a_lamp_cause: assert property ($rose(run_lamp_green) |-> $past(toggle_req)) // R2
        else $error("run lamp lit without a start request");
    a_bus_lamp: assert property (aresetn |=> bus_lamp == $past(bus_traffic)) // R3
        else $error("bus lamp does not follow traffic");
    a_ack_live: assert property (ack_error_event ##1 run |=> live_led[EV_ACK]) // R5
        else $error("acknowledge event missing on live lamp");
    a_quality_live: assert property ((meas_quality < qual_thr_r) ##1 run |=> live_led[EV_QUAL]) // R6
        else $error("quality event missing");
    a_volt_live: assert property ((meas_volt_margin < volt_min_r) ##1 run |=> live_led[EV_VOLT]) // R7
        else $error("voltage margin event missing");
    a_edge_live: assert property ((meas_edge_up > up_lim_r) ##1 run |=> live_led[EV_EDGE_UP]) // R8
        else $error("rising edge event missing");
    a_start_clear: assert property ($rose(run) |-> latch_led == '0 && live_led == '0) // R9
        else $error("lamps not dark at start");
    a_live_gate: assert property (|live_led |-> $past(run)) // R10
        else $error("live lamp on while not monitoring");
    a_latch_hold: assert property (!start_evt |=> (latch_led & $past(latch_led)) == $past(latch_led)) // R11
        else $error("latched lamp dropped before restart");
    a_iso_mirror: assert property (1'b1 |=> iso_err_out == |($past(live_led & route_r))) // R12
        else $error("isolated output does not mirror routed events");
    a_factory_restore: assert property (factory_r |=> qual_thr_r == QUAL_THR_DEF && !run) // R13
        else $error("factory restore incomplete");
endmodule
`default_nettype wire

// ### verification/mei_operator_model.sv
// Purpose: Operator at the run and rear reset buttons of the monitor.
// Assumes: Buttons read high while pressed and low when released.
// Notes: Chatter is a train of pulses shorter than the debounce span.
`timescale 1ns/1ps
`default_nettype none
module mei_operator_model (
    input wire logic aclk,
    output logic run_btn_pin,
    output logic reset_btn_pin
);
    // Released buttons rest low through their pull-downs
    initial begin
        run_btn_pin = 1'b0;
        reset_btn_pin = 1'b0;
    end

    // Contact chatter, then an optional firm press and release
    task automatic press(input int bounces, input bit firm);
        @(posedge aclk);
        for (int i = 0; i < bounces; i++) begin
            run_btn_pin <= 1'b1;
            repeat (2) @(posedge aclk);
            run_btn_pin <= 1'b0;
            repeat (2) @(posedge aclk);
        end
        if (firm) begin
            run_btn_pin <= 1'b1;
            repeat (16) @(posedge aclk);
            run_btn_pin <= 1'b0;
            repeat (16) @(posedge aclk);
        end
    endtask

    // Rear button held for a number of cycles
    task automatic hold_reset(input int n);
        @(posedge aclk);
        reset_btn_pin <= 1'b1;
        repeat (n) @(posedge aclk);
        reset_btn_pin <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ### verification/tb.sv
// Purpose: Self-checking bench of the monitor run control and indicators.
// Assumes: Debounce and hold counts shortened to keep the run brief.
// Notes: Bus traffic is random every cycle from a fixed-seed LFSR.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import mei_pkg::*;
    localparam int DB = 4;
    localparam int HOLD = 20;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb, ev;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic run_btn_pin, reset_btn_pin, bus_traffic, run_lamp_green, bus_lamp;
    logic iso_err_out, factory_reset, irq, prev_traffic;
    logic prev_up = 1'b0;
    logic [QUAL_W-1:0] meas_quality;
    logic [VOLT_W-1:0] meas_volt_margin;
    logic [EDGE_W-1:0] meas_edge_up, meas_edge_down;
    logic [NCLS-1:0] live_led, latch_led;
    logic [31:0] rnd = 32'h25cd;
    int n_errors = 0;
    int samples_checked = 0;
    int fr_cnt = 0;

    mei_top #(.DEBOUNCE_CYCLES(DB), .HOLD_CYCLES(HOLD)) mei_top_inst (.aclk, .aresetn,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .run_btn_pin, .reset_btn_pin, .bus_traffic,
        .active_error_frame_event(ev[0]), .passive_error_frame_event(ev[1]),
        .overload_frame_event(ev[2]), .ack_error_event(ev[3]), .meas_quality,
        .meas_volt_margin, .meas_edge_up, .meas_edge_down, .run_lamp_green, .bus_lamp,
        .live_led, .latch_led, .iso_err_out, .factory_reset, .irq);
    mei_operator_model mei_operator_model_inst (.aclk, .run_btn_pin, .reset_btn_pin);

    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Latched lamps expected after classes 0..i have fired
    function automatic logic [7:0] upto(input int i);
        return 8'((16'h2 << i) - 16'h1);
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask

    // Write: address and data offered together, each dropped once taken
    task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        chk(s_axi_bresp, er);
    endtask

    task automatic rd(input logic [5:0] a, input logic [31:0] ed, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        chk(s_axi_rdata, ed);
        chk(s_axi_rresp, er);
    endtask

    // Quiet measurements sit on or beyond the limit, so the boundary never trips
    task automatic drive(input int i, input bit on);
        case (i)
            4: meas_quality <= on ? QUAL_THR_DEF - 7'h1 : QUAL_THR_DEF + 7'(rnd[4:0]);
            5: meas_volt_margin <= on ? VOLT_MIN_DEF - 12'h1 : VOLT_MIN_DEF + 12'(rnd[7:0]);
            6: meas_edge_up <= on ? EDGE_LIM_DEF + 7'h1 : EDGE_LIM_DEF - 7'(rnd[3:0]);
            7: meas_edge_down <= on ? EDGE_LIM_DEF + 7'h1 : EDGE_LIM_DEF - 7'(rnd[3:0]);
            default: ev[i] <= on;
        endcase
    endtask

    task automatic end_of_test;
        if (n_errors == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Random traffic, lamp follows one cycle late, rear pulses counted
    always @(posedge aclk) begin
        rnd <= lfsr(rnd);
        bus_traffic <= rnd[0];
        if (prev_up && aresetn) chk(bus_lamp, prev_traffic);
        prev_traffic <= bus_traffic;
        prev_up <= aresetn;
        if (factory_reset === 1'b1) fr_cnt <= fr_cnt + 1;
    end

    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
        // Response ready stays high, so back-to-back calls never retoggle it
        {s_axi_bready, s_axi_rready} = 2'b11;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, ev} = '0;
        s_axi_wstrb = 4'hf;
        meas_quality = QUAL_THR_DEF;
        meas_volt_margin = VOLT_MIN_DEF;
        meas_edge_up = EDGE_LIM_DEF;
        meas_edge_down = EDGE_LIM_DEF;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        cyc(2);
        chk({run_lamp_green, live_led, latch_led}, 0);
        rd(OFF_QUAL_THR, 32'h32, RESP_OKAY);
        rd(OFF_VOLT_MIN, 32'h4b0, RESP_OKAY);
        rd(OFF_EDGE_DN_LIM, 32'h10, RESP_OKAY);
        rd(6'h3c, 32'h0, RESP_SLVERR);
        wr(6'h3c, 32'h1, RESP_SLVERR);
        wr(OFF_ERR_ROUTE, 32'h8, RESP_OKAY);
        for (int i = 0; i < NCLS; i++) drive(i, 1'b1);
        cyc(4);
        chk({live_led, latch_led}, 0);
        for (int i = 0; i < NCLS; i++) drive(i, 1'b0);
        mei_operator_model_inst.press(3, 1'b0);
        chk(run_lamp_green, 1'b0);
        mei_operator_model_inst.press(3, 1'b1);
        chk(run_lamp_green, 1'b1);
        wr(OFF_IRQ_STATUS, 32'h7ff, RESP_OKAY);
        for (int i = 0; i < NCLS; i++) begin
            drive(i, 1'b1);
            cyc(4);
            chk(live_led, 8'h1 << i);
            chk(latch_led, upto(i));
            drive(i, 1'b0);
            cyc(4);
            chk({live_led, latch_led}, {8'h0, upto(i)});
        end
        rd(OFF_IRQ_STATUS, 32'hff, RESP_OKAY);
        wr(OFF_IRQ_MASK, 32'h8, RESP_OKAY);
        cyc(2);
        chk(irq, 1'b1);
        wr(OFF_IRQ_STATUS, 32'h7ff, RESP_OKAY);
        cyc(2);
        chk(irq, 1'b0);
        // Class already latched: no new first occurrence, so no interrupt
        drive(3, 1'b1);
        cyc(4);
        chk({irq, iso_err_out}, 2'b01);
        drive(3, 1'b0);
        cyc(4);
        chk(iso_err_out, 1'b0);
        wr(OFF_IRQ_STATUS, 32'h8, RESP_OKAY);
        drive(2, 1'b1);
        cyc(4);
        chk({irq, iso_err_out}, 2'b00);
        drive(2, 1'b0);
        drive(0, 1'b1);
        mei_operator_model_inst.press(0, 1'b1);
        chk({run_lamp_green, live_led, latch_led}, {1'b0, 8'h0, 8'hff});
        rd(OFF_STATE, 32'h00ff_0000, RESP_OKAY);
        drive(0, 1'b0);
        mei_operator_model_inst.press(0, 1'b1);
        chk({run_lamp_green, live_led, latch_led}, {1'b1, 16'h0});
        rd(OFF_STATE, 32'h1, RESP_OKAY);
        wr(OFF_CTRL, 32'h1, RESP_OKAY);
        chk(run_lamp_green, 1'b0);
        wr(OFF_CTRL, 32'h1, RESP_OKAY);
        chk(run_lamp_green, 1'b1);
        rd(OFF_CTRL, 32'h0, RESP_OKAY);
        wr(OFF_QUAL_THR, 32'h20, RESP_OKAY);
        mei_operator_model_inst.hold_reset(DB + HOLD + 12);
        cyc(4);
        chk(fr_cnt, 1);
        chk(run_lamp_green, 1'b0);
        rd(OFF_QUAL_THR, 32'h32, RESP_OKAY);
        end_of_test;
    end

    // Watchdog sized well beyond the sequence above
    initial begin
        repeat (5000) @(posedge aclk);
        n_errors++;
        end_of_test;
    end
endmodule
`default_nettype wire
